// ===== pwaalu_top.sv
// datapath slice: xnor, paired-word vector ops, accumulator and status
//
// Overview of operation
// RQ1: xnor op writes inverted xor of source operand and operand b to operand a.
// RQ2: with record flag, condition field zero gets sign/zero of low word and summary.
// RQ3: vector abs per lane; most negative value passes, no overflow flagged.
// RQ4: zero-extended 5-bit immediate added to both lanes of operand b.
// RQ5: signed modulo accumulate-add writes destination and accumulator.
// RQ6: signed saturating accumulate-add clamps on overflow or underflow.
// RQ7: saturating forms write per-lane current overflow flags.
// RQ8: saturating forms OR lane overflow into sticky flags until software clears.
// RQ9: unsigned modulo accumulate-add writes destination and accumulator.
// RQ10: unsigned saturating accumulate-add clamps on carry out.
// RQ11: unsigned saturating form records overflow like signed form.
// RQ12: signed clamps to 7fffffff/80000000, unsigned to ffffffff.
//
// The implementer's own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`include "pwaalu_regs.svh"
module pwaalu_top (
   input  wire logic        CLOCK,
   input  wire logic        RESET_N,
   input  wire logic        ISSUE,
   input  wire logic [2:0]  OPCODE,
   input  wire logic        RECORD_FLAG,
   input  wire logic        SUMMARY_IN,
   input  wire logic [63:0] SOURCE_OPERAND,
   input  wire logic [63:0] OPERAND_A,
   input  wire logic [63:0] OPERAND_B,
   input  wire logic [4:0]  SMALL_IMMEDIATE,
   output logic      [63:0] RESULT,
   output logic             RESULT_VALID,
   output logic             FIELD_WRITE,
   output logic      [3:0]  CONDITION_FIELD_ZERO,
   input  wire logic [3:0]  REG_ADDR,
   input  wire logic [31:0] REG_WDATA,
   input  wire logic        REG_WR,
   input  wire logic        REG_RD,
   output logic      [31:0] REG_RDATA,
   output logic             IRQ
);
   // ***************************************************
   // declarations
   // ***************************************************
   pwaalu_lane_if          lane_hi ();
   pwaalu_lane_if          lane_lo ();
   pwaalu_pkg::pwaalu_op_type op;
   logic [63:0]            running_sum_register_q;
   logic [3:0]             vector_status_reg_q;
   logic [1:0]             irq_st_q;
   logic [1:0]             irq_en_q;
   logic [63:0]            result_d;
   logic [3:0]             field_d;
   logic                   is_acc;
   logic                   is_sat;
   logic [1:0]             ev;

   assign op = pwaalu_pkg::pwaalu_op_type'(OPCODE);

   // is the op one of the accumulate adds
   function automatic logic acc_op(input pwaalu_pkg::pwaalu_op_type o);
      acc_op = (o == pwaalu_pkg::PWAALU_OP_ADD_SM) || (o == pwaalu_pkg::PWAALU_OP_ADD_SS) ||
               (o == pwaalu_pkg::PWAALU_OP_ADD_UM) || (o == pwaalu_pkg::PWAALU_OP_ADD_US);
   endfunction

   // is the op a saturating accumulate add
   function automatic logic sat_op(input pwaalu_pkg::pwaalu_op_type o);
      sat_op = (o == pwaalu_pkg::PWAALU_OP_ADD_SS) || (o == pwaalu_pkg::PWAALU_OP_ADD_US);
   endfunction

   assign is_acc = acc_op(op);
   assign is_sat = sat_op(op);

   // ***************************************************
   // lane operand steering
   // ***************************************************
   always_comb begin
      lane_hi.op = op;
      lane_lo.op = op;
      lane_hi.a  = OPERAND_A[63:32];
      lane_lo.a  = OPERAND_A[31:0];
      if (op == pwaalu_pkg::PWAALU_OP_ADDI) begin
         lane_hi.a = {27'h0, SMALL_IMMEDIATE}; // RQ4
         lane_lo.a = {27'h0, SMALL_IMMEDIATE}; // RQ4
         lane_hi.b = OPERAND_B[63:32];
         lane_lo.b = OPERAND_B[31:0];
      end else begin
         lane_hi.b = running_sum_register_q[63:32]; // RQ5 RQ9
         lane_lo.b = running_sum_register_q[31:0];
      end
   end

   pwaalu_lane u_lane_hi (
      .lp (lane_hi)
   );

   pwaalu_lane u_lane_lo (
      .lp (lane_lo)
   );

   // result select: xnor or the lane pair
   always_comb begin
      if (op == pwaalu_pkg::PWAALU_OP_XNOR) begin
         result_d = ~(SOURCE_OPERAND ^ OPERAND_B); // RQ1
      end else begin
         result_d = {lane_hi.y, lane_lo.y};
      end
   end

   pwaalu_flags u_flags (
      .word    (result_d[31:0]),
      .summary (SUMMARY_IN),
      .field   (field_d)
   );

   // ***************************************************
   // result outputs
   // ***************************************************
   always_ff @(posedge CLOCK) begin
      if (!RESET_N) begin
         RESULT       <= 64'h0;
         RESULT_VALID <= 1'b0;
      end else begin
         RESULT_VALID <= ISSUE;
         if (ISSUE) begin
            RESULT <= result_d; // RQ1
         end
      end
   end

   // condition field zero update
   always_ff @(posedge CLOCK) begin
      if (!RESET_N) begin
         FIELD_WRITE          <= 1'b0;
         CONDITION_FIELD_ZERO <= 4'h0;
      end else begin
         FIELD_WRITE <= ISSUE && RECORD_FLAG && op == pwaalu_pkg::PWAALU_OP_XNOR; // RQ2
         if (ISSUE && RECORD_FLAG && op == pwaalu_pkg::PWAALU_OP_XNOR) begin
            CONDITION_FIELD_ZERO <= field_d; // RQ2
         end
      end
   end

   // ***************************************************
   // accumulator
   // ***************************************************
   always_ff @(posedge CLOCK) begin
      if (!RESET_N) begin
         running_sum_register_q <= 64'h0;
      end else if (ISSUE && is_acc) begin
         running_sum_register_q <= result_d; // RQ5 RQ6 RQ9 RQ10
      end
   end

   // ***************************************************
   // vector status: current and sticky overflow
   // ***************************************************
   always_ff @(posedge CLOCK) begin
      if (!RESET_N) begin
         vector_status_reg_q <= `PWAALU_STATUS_RST;
      end else begin
         // software clears sticky bits by writing one; a new overflow wins
         if (REG_WR && REG_ADDR == `PWAALU_OFF_STATUS) begin
            vector_status_reg_q[`PWAALU_BIT_LO_STICKY] <=
               vector_status_reg_q[`PWAALU_BIT_LO_STICKY] & ~REG_WDATA[`PWAALU_BIT_LO_STICKY];
            vector_status_reg_q[`PWAALU_BIT_HI_STICKY] <=
               vector_status_reg_q[`PWAALU_BIT_HI_STICKY] & ~REG_WDATA[`PWAALU_BIT_HI_STICKY];
         end
         if (ISSUE && is_sat) begin
            vector_status_reg_q[`PWAALU_BIT_LO_SAT] <= lane_lo.sat; // RQ7 RQ11
            vector_status_reg_q[`PWAALU_BIT_HI_SAT] <= lane_hi.sat; // RQ7 RQ11
            if (lane_lo.sat) begin
               vector_status_reg_q[`PWAALU_BIT_LO_STICKY] <= 1'b1; // RQ8 RQ11
            end
            if (lane_hi.sat) begin
               vector_status_reg_q[`PWAALU_BIT_HI_STICKY] <= 1'b1; // RQ8 RQ11
            end
         end
      end
   end

   // ***************************************************
   // interrupts: saturation event and instruction done
   // ***************************************************
   assign ev[`PWAALU_EV_SAT]  = ISSUE && is_sat && (lane_lo.sat || lane_hi.sat);
   assign ev[`PWAALU_EV_DONE] = ISSUE;

   // sticky events, set wins over clear
   always_ff @(posedge CLOCK) begin
      if (!RESET_N) begin
         irq_st_q <= 2'h0;
      end else if (REG_WR && REG_ADDR == `PWAALU_OFF_IRQ_CLR) begin
         irq_st_q <= (irq_st_q & ~REG_WDATA[1:0]) | ev;
      end else begin
         irq_st_q <= irq_st_q | ev;
      end
   end

   // enable register
   always_ff @(posedge CLOCK) begin
      if (!RESET_N) begin
         irq_en_q <= 2'h0;
      end else if (REG_WR && REG_ADDR == `PWAALU_OFF_IRQ_EN) begin
         irq_en_q <= REG_WDATA[1:0];
      end
   end

   // interrupt level from sticky state or this cycle's events
   always_ff @(posedge CLOCK) begin
      if (!RESET_N) begin
         IRQ <= 1'b0;
      end else begin
         IRQ <= |((irq_st_q | ev) & irq_en_q);
      end
   end

   // ***************************************************
   // register read port, data one cycle after strobe
   // ***************************************************
   always_ff @(posedge CLOCK) begin
      if (!RESET_N) begin
         REG_RDATA <= 32'h0;
      end else if (REG_RD) begin
         case (REG_ADDR)
            `PWAALU_OFF_STATUS: REG_RDATA <= {28'h0, vector_status_reg_q};
            `PWAALU_OFF_IRQ_ST: REG_RDATA <= {30'h0, irq_st_q};
            `PWAALU_OFF_IRQ_EN: REG_RDATA <= {30'h0, irq_en_q};
            `PWAALU_OFF_SUM_HI: REG_RDATA <= running_sum_register_q[63:32];
            `PWAALU_OFF_SUM_LO: REG_RDATA <= running_sum_register_q[31:0];
            `PWAALU_OFF_FIELD:  REG_RDATA <= {28'h0, CONDITION_FIELD_ZERO};
            default:            REG_RDATA <= 32'h0;
         endcase
      end else begin
         REG_RDATA <= 32'h0;
      end
   end
endmodule

// ===== pwaalu_regs.svh
// constants: status bit positions, reset values, saturation limits and register offsets
`ifndef PWAALU_REGS_SVH
`define PWAALU_REGS_SVH
// ***************************************************
// register offsets (word index on the plain port)
// ***************************************************
`define PWAALU_OFF_STATUS   4'h0
`define PWAALU_OFF_IRQ_ST   4'h1
`define PWAALU_OFF_IRQ_EN   4'h2
`define PWAALU_OFF_IRQ_CLR  4'h3
`define PWAALU_OFF_SUM_HI   4'h4
`define PWAALU_OFF_SUM_LO   4'h5
`define PWAALU_OFF_FIELD    4'h6
// ***************************************************
// vector status field positions
// ***************************************************
`define PWAALU_BIT_LO_SAT     0
`define PWAALU_BIT_HI_SAT     1
`define PWAALU_BIT_LO_STICKY  2
`define PWAALU_BIT_HI_STICKY  3
`define PWAALU_STATUS_RST   4'h0
// ***************************************************
// interrupt event bits
// ***************************************************
`define PWAALU_EV_SAT       0
`define PWAALU_EV_DONE      1
// ***************************************************
// saturation limits
// ***************************************************
`define PWAALU_SMAX         32'h7fffffff
`define PWAALU_SMIN         32'h80000000
`define PWAALU_UMAX         32'hffffffff
`endif

// ===== pwaalu_pkg.sv
// package: operation codes of the datapath slice
package pwaalu_pkg;
   typedef enum logic [2:0] {
      PWAALU_OP_XNOR,
      PWAALU_OP_ABS,
      PWAALU_OP_ADDI,
      PWAALU_OP_ADD_SM,
      PWAALU_OP_ADD_SS,
      PWAALU_OP_ADD_UM,
      PWAALU_OP_ADD_US
   } pwaalu_op_type;
   typedef enum logic {
      PWAALU_IDLE,
      PWAALU_BUSY
   } pwaalu_state_type;
endpackage

// ===== pwaalu_lane_if.sv
// interface: one 32-bit lane operation and its answer
`timescale 1ns/1ps
interface pwaalu_lane_if;
   logic [31:0]        a;
   logic [31:0]        b;
   pwaalu_pkg::pwaalu_op_type op;
   logic [31:0]        y;
   logic               sat;
   modport ctl  (output a, output b, output op, input  y, input  sat);
   modport lane (input  a, input  b, input  op, output y, output sat);
endinterface

// ===== pwaalu_lane.sv
// one 32-bit lane: absolute value, immediate add and accumulate adds
`timescale 1ns/1ps
`include "pwaalu_regs.svh"
module pwaalu_lane (
   pwaalu_lane_if.lane lp
);
   logic [32:0] sum;
   // lane arithmetic, b carries accumulator lane or operand b, a carries operand a or immediate
   always_comb begin
      sum    = {1'b0, lp.a} + {1'b0, lp.b};
      lp.y   = sum[31:0];
      lp.sat = 1'b0;
      case (lp.op)
         pwaalu_pkg::PWAALU_OP_ABS: begin
            lp.y = lp.a[31] ? (32'h0 - lp.a) : lp.a; // RQ3
         end
         pwaalu_pkg::PWAALU_OP_ADD_SS: begin
            // same-signed operands giving another sign overflow
            if (lp.a[31] == lp.b[31] && sum[31] != lp.a[31]) begin
               lp.sat = 1'b1; // RQ6
               lp.y   = lp.a[31] ? `PWAALU_SMIN : `PWAALU_SMAX; // RQ12
            end
         end
         pwaalu_pkg::PWAALU_OP_ADD_US: begin
            if (sum[32]) begin
               lp.sat = 1'b1; // RQ10
               lp.y   = `PWAALU_UMAX; // RQ12
            end
         end
         default: begin
            lp.y = sum[31:0]; // RQ4 RQ5 RQ9
         end
      endcase
   end
endmodule

// ===== pwaalu_flags.sv
// condition field zero from the low word of a result
`timescale 1ns/1ps
module pwaalu_flags (
   input  wire logic [31:0] word,
   input  wire logic        summary,
   output logic      [3:0]  field
);
   // negative, positive, zero, summary copy
   always_comb begin
      field = {word[31], ~word[31] & (|word), ~(|word), summary}; // RQ2
   end
endmodule

// ===== pwaalu_top_sva.sv
// checker: timing and datapath relations seen at the slice ports
`timescale 1ns/1ps
module pwaalu_top_sva (
   input wire logic        CLOCK,
   input wire logic        RESET_N,
   input wire logic        ISSUE,
   input wire logic [2:0]  OPCODE,
   input wire logic        RECORD_FLAG,
   input wire logic        SUMMARY_IN,
   input wire logic [63:0] SOURCE_OPERAND,
   input wire logic [63:0] OPERAND_A,
   input wire logic [63:0] OPERAND_B,
   input wire logic [4:0]  SMALL_IMMEDIATE,
   input wire logic [63:0] RESULT,
   input wire logic        RESULT_VALID,
   input wire logic        FIELD_WRITE,
   input wire logic [3:0]  CONDITION_FIELD_ZERO,
   input wire logic [3:0]  REG_ADDR,
   input wire logic [31:0] REG_WDATA,
   input wire logic        REG_WR,
   input wire logic        REG_RD,
   input wire logic [31:0] REG_RDATA,
   input wire logic        IRQ
);
   // one clock domain
   default clocking @(posedge CLOCK);
   endclocking
   default disable iff (!RESET_N);
   issue_valid_a: assert property (ISSUE |=> RESULT_VALID) else $error("valid missing");
   valid_only_a: assert property (!ISSUE |=> !RESULT_VALID) else $error("stray valid");
   result_hold_a: assert property (!ISSUE |=> $stable(RESULT)) else $error("result moved");
   xnor_value_a: assert property (ISSUE && OPCODE == 3'h0 |=>
      RESULT == ~($past(SOURCE_OPERAND) ^ $past(OPERAND_B))) else $error("xnor wrong");
   field_pulse_a: assert property (ISSUE && OPCODE == 3'h0 && RECORD_FLAG |=> FIELD_WRITE)
      else $error("field write missing");
   field_only_a: assert property (!(ISSUE && OPCODE == 3'h0 && RECORD_FLAG) |=>
      !FIELD_WRITE) else $error("stray field write");
   field_bits_a: assert property (FIELD_WRITE |-> CONDITION_FIELD_ZERO == {RESULT[31],
      !RESULT[31] && RESULT[31:0] != 32'h0, RESULT[31:0] == 32'h0, $past(SUMMARY_IN)})
      else $error("field bits wrong");
   abs_high_a: assert property (ISSUE && OPCODE == 3'h1 |=> RESULT[63:32] ==
      ($past(OPERAND_A[63]) ? -$past(OPERAND_A[63:32]) : $past(OPERAND_A[63:32])))
      else $error("abs wrong");
   addi_lanes_a: assert property (ISSUE && OPCODE == 3'h2 |=>
      RESULT == {$past(OPERAND_B[63:32]) + {27'h0, $past(SMALL_IMMEDIATE)},
                 $past(OPERAND_B[31:0]) + {27'h0, $past(SMALL_IMMEDIATE)}})
      else $error("add immediate wrong");
   rdata_idle_a: assert property (!REG_RD |=> REG_RDATA == 32'h0) else $error("read data stray");
endmodule
bind pwaalu_top pwaalu_top_sva pwaalu_top_sva_i (.*);

// ===== pwaalu_core_model.sv
// partner: issue side of the core, one instruction per call
`timescale 1ns/1ps
module pwaalu_core_model (
   input  wire logic        clock,
   output logic             issue,
   output logic      [2:0]  opcode,
   output logic             record_flag,
   output logic             summary_in,
   output logic      [63:0] source_operand,
   output logic      [63:0] operand_a,
   output logic      [63:0] operand_b,
   output logic      [4:0]  small_immediate
);
   // idle until the first issue
   initial begin
      {issue, opcode, record_flag, summary_in} = '0;
      {source_operand, operand_a, operand_b, small_immediate} = '0;
   end
   // one-cycle issue pulse, operands turned over once taken
   task send(input logic [2:0] op, input logic [63:0] s, a, b, input logic [4:0] imm,
             input logic rec, sm);
      @(posedge clock);
      {issue, opcode, record_flag, summary_in} <= {1'b1, op, rec, sm};
      {source_operand, operand_a, operand_b, small_immediate} <= {s, a, b, imm};
      @(posedge clock);
      {issue, record_flag, summary_in} <= {1'b0, ~rec, ~sm};
      {source_operand, operand_a, operand_b, small_immediate} <= ~{s, a, b, imm};
   endtask
endmodule

// ===== pwaalu_top_tb.sv
// testbench: opcodes cycled in turn with random operands against a behavioural model
`timescale 1ns/1ps
`include "pwaalu_regs.svh"
module pwaalu_top_tb;
   logic        clock, reset_n, issue, rec_f, sum_f, valid, fld_w, irq, reg_wr, reg_rd, rec, sm;
   logic [2:0]  opc, op;
   logic [3:0]  cond, reg_addr, sts, cf;
   logic [4:0]  imm_w, imm;
   logic [31:0] reg_wdata, reg_rdata, acc [2];
   logic [63:0] src_w, a_w, b_w, result, s, a, b, exp;
   logic [1:0]  ist;
   integer      seed, bad_count, comparisons, i;
   pwaalu_core_model pwaalu_core_model_i (.clock(clock), .issue(issue), .opcode(opc),
      .record_flag(rec_f), .summary_in(sum_f), .source_operand(src_w), .operand_a(a_w),
      .operand_b(b_w), .small_immediate(imm_w));
   pwaalu_top pwaalu_top_i (.CLOCK(clock), .RESET_N(reset_n), .ISSUE(issue), .OPCODE(opc),
      .RECORD_FLAG(rec_f), .SUMMARY_IN(sum_f), .SOURCE_OPERAND(src_w), .OPERAND_A(a_w),
      .OPERAND_B(b_w), .SMALL_IMMEDIATE(imm_w), .RESULT(result), .RESULT_VALID(valid),
      .FIELD_WRITE(fld_w), .CONDITION_FIELD_ZERO(cond), .REG_ADDR(reg_addr),
      .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
      .IRQ(irq));
   // clock
   always #5 clock = ~clock;
   // compare and count
   task chk(input logic [65:0] seen, input logic [65:0] want);
      comparisons = comparisons + 1;
      if (seen !== want) begin
         bad_count = bad_count + 1;
         $display("unexpected at %0t seen %h expected %h", $time, seen, want);
      end
   endtask
   task close_out;
      $display("mismatches %0d comparisons %0d", bad_count, comparisons);
      if (bad_count == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // register port cycles
   task wr(input logic [3:0] ad, input logic [31:0] d);
      @(posedge clock);
      {reg_wr, reg_addr, reg_wdata} <= {1'b1, ad, d};
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask
   task rd(input logic [3:0] ad, input logic [31:0] want);
      @(posedge clock);
      {reg_rd, reg_addr} <= {1'b1, ad};
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, want);
   endtask
   task irq_chk(input logic want);
      repeat (2) @(posedge clock);
      #1 chk(irq, want);
   endtask
   // reference model: lanes, accumulator, status and events
   task model;
      longint sum;
      logic [1:0] ov;
      ov = 2'b00;
      for (int l = 0; l < 2; l++) begin
         sum = longint'($signed(a[l*32 +: 32])) + longint'($signed(acc[l]));
         case (op)
            3'h0: exp[l*32 +: 32] = ~(s[l*32 +: 32] ^ b[l*32 +: 32]);
            3'h1: exp[l*32 +: 32] = a[l*32+31] ? -a[l*32 +: 32] : a[l*32 +: 32];
            3'h2: exp[l*32 +: 32] = b[l*32 +: 32] + imm;
            3'h4: exp[l*32 +: 32] = sum > 64'sd2147483647 ? `PWAALU_SMAX :
                                    sum < -64'sd2147483648 ? `PWAALU_SMIN : sum[31:0];
            3'h6: begin
               sum = longint'(a[l*32 +: 32]) + longint'(acc[l]);
               exp[l*32 +: 32] = sum[32] ? `PWAALU_UMAX : sum[31:0];
            end
            default: exp[l*32 +: 32] = a[l*32 +: 32] + acc[l];
         endcase
         ov[l] = exp[l*32 +: 32] != sum[31:0];
         if (op >= 3'h3 && op <= 3'h6) acc[l] = exp[l*32 +: 32];
      end
      if (op == 3'h4 || op == 3'h6) sts = {sts[3:2] | ov, ov};
      ist = ist | {1'b1, (op == 3'h4 || op == 3'h6) && (|ov)};
   endtask
   // watchdog
   initial begin
      #200000;
      bad_count = bad_count + 1;
      close_out;
   end
   // main sequence
   initial begin
      {clock, reset_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
      {seed, bad_count, comparisons, sts, ist, cf} = {32'h51e1e302, 64'h0, 10'h0};
      {acc[0], acc[1]} = '0;
      repeat (3) @(posedge clock);
      reset_n <= 1'b1;
      #1 chk({irq, valid, result}, 0);
      for (i = 0; i < 84; i++) begin
         op = 3'(i % 8);
         {s, a, b} = {$random(seed), $random(seed), $random(seed), $random(seed),
                      $random(seed), $random(seed)};
         {imm, rec, sm} = $random(seed);
         if (i % 16 == 1) a[31:0] = 32'h80000000;
         model;
         pwaalu_core_model_i.send(op, s, a, b, imm, rec, sm);
         #1 chk({valid, result}, {1'b1, exp});
         chk(fld_w, op == 3'h0 && rec);
         if (op == 3'h0 && rec) cf = {exp[31], !exp[31] && exp[31:0] != 0,
                                      exp[31:0] == 0, sm};
         chk(cond, cf);
         rd(4'h0, {28'h0, sts});
         rd(4'h5, acc[0]);
         if (i == 40) begin
            wr(4'h0, 32'hc); // sticky clear by software
            sts[3:2] = 2'b00;
         end
      end
      // read-only, unmapped and interrupt paths
      wr(4'h5, 32'h0);
      rd(4'h5, acc[0]);
      rd(4'h4, acc[1]);
      rd(4'hf, 32'h0);
      rd(4'h6, {28'h0, cf});
      rd(4'h1, {30'h0, ist});
      wr(4'h2, 32'h3);
      irq_chk(|ist);
      wr(4'h3, 32'h1);
      ist[0] = 1'b0;
      irq_chk(ist[1]);
      wr(4'h2, 32'h1);
      irq_chk(1'b0);
      wr(4'h3, 32'h3);
      rd(4'h1, 32'h0);
      close_out;
   end
endmodule
